// ===== rtl/srb_pkg.sv
package srb_pkg;
   localparam int CMD_W   = 29;
   localparam int RB_W    = 24;
   localparam int ZERO_W  = CMD_W - RB_W;
   localparam int SHORT_W = 24;

   localparam int BIT_RW     = 28;
   localparam int CHAN_MSB   = 27;
   localparam int CHAN_LSB   = 24;
   localparam int CLASS_MSB  = 23;
   localparam int CLASS_LSB  = 22;
   localparam int DATA_MSB   = 21;
   localparam int ADDR_MSB   = 5;

   localparam logic [1:0] CLS_SYS   = 2'h0;
   localparam logic [1:0] CLS_CMP   = 2'h1;
   localparam logic [1:0] CLS_RSVD  = 2'h2;
   localparam logic [1:0] CLS_ALARM = 2'h3;
   localparam logic [1:0] CLS_CHAN  = 2'h0;
   localparam logic [1:0] CLS_GAIN  = 2'h1;
   localparam logic [1:0] CLS_OFFS  = 2'h2;
   localparam logic [1:0] CLS_INPUT = 2'h3;

   localparam logic [5:0] DAC_SHARED_OFFSET = 6'h00;

   localparam logic [4:0] EDGE_FIRST = 5'h00;
   localparam logic [4:0] EDGE_LAST  = 5'h1C;
   localparam logic [4:0] EDGE_SAT   = 5'h1F;
   localparam logic [ZERO_W-1:0] FILL_ZERO = 5'h00;

   localparam logic [1:0] PH_RISE   = 2'h0;
   localparam logic [1:0] PH_FALL   = 2'h2;
   localparam logic [1:0] PH_SAMPLE = 2'h3;
   localparam logic [4:0] BITS_LONG  = 5'h1C;
   localparam logic [4:0] BITS_SHORT = 5'h17;
   localparam logic [4:0] RX_BITS    = 5'h18;
   localparam logic [4:0] GAP_CYC    = 5'h10;
   localparam logic [23:0] FLUSH_CMD = 24'hFFFFFF;
endpackage

// ===== rtl/srb_if.sv
`timescale 1ns/100ps
interface srb_if;
   logic sclk;
   logic syncN;
   logic sdi;
   logic sdo;

   modport dev
   (
      input  sclk,
      input  syncN,
      input  sdi,
      output sdo
   );

   modport host
   (
      output sclk,
      output syncN,
      output sdi,
      input  sdo
   );
endinterface

// ===== rtl/srb_host.sv
`timescale 1ns/100ps
module srb_host (
   srb_if.host               link,
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         cmdValid,
   input  wire logic         cmdShort,
   input  wire logic [28:0]  cmdWord,
   output logic              cmdReady,
   output logic              rspValid,
   output logic [23:0]       rspData
);
   typedef enum logic [3:0]
   {
      ST_IDLE  = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_GAP   = 4'b1000
   } srb_hstate_e;

   typedef struct packed {
      srb_hstate_e  state;
      logic [1:0]   ph;
      logic [4:0]   bitsLeft;
      logic [4:0]   rxCnt;
      logic [4:0]   gap;
      logic [28:0]  tx;
      logic [23:0]  rx;
      logic [1:0]   sdoSync;
      logic         sclk;
      logic         syncN;
      logic         sdi;
      logic         ready;
      logic         rspValid;
      logic [23:0]  rspData;
   } srb_host_s;

   srb_host_s h_q;
   srb_host_s h_d;
   logic [23:0] rxNext;

   always_comb
   begin
      h_d = h_q;
      h_d.sdoSync = {h_q.sdoSync[0], link.sdo};
      h_d.rspValid = 1'b0;
      rxNext = h_q.rx;
      if (h_q.rxCnt < srb_pkg::RX_BITS)
      begin
         rxNext = {h_q.rx[22:0], h_q.sdoSync[1]};
      end
      unique case (h_q.state)
         ST_IDLE:
         begin
            if (cmdValid && h_q.ready)
            begin
               // Short frames carry the command in the top 24 bits
               h_d.tx = cmdShort ? {cmdWord[23:0], srb_pkg::FILL_ZERO} : cmdWord;
               h_d.bitsLeft = cmdShort ? srb_pkg::BITS_SHORT : srb_pkg::BITS_LONG;
               h_d.sdi = cmdShort ? cmdWord[23] : cmdWord[28];
               h_d.syncN = 1'b0;
               h_d.ready = 1'b0;
               h_d.rxCnt = 5'h00;
               h_d.ph = 2'h0;
               h_d.state = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            h_d.state = ST_SHIFT;
         end
         ST_SHIFT:
         begin
            h_d.ph = h_q.ph + 2'h1;
            if (h_q.ph == srb_pkg::PH_RISE)
            begin
               h_d.sclk = 1'b1;
            end
            if (h_q.ph == srb_pkg::PH_FALL)
            begin
               h_d.sclk = 1'b0;
            end
            if (h_q.ph == srb_pkg::PH_SAMPLE)
            begin
               h_d.rx = rxNext;
               h_d.rxCnt = h_q.rxCnt + 5'h01;
               if (h_q.bitsLeft == 5'h00)
               begin
                  // Every command delivers at least 24 rising edges
                  h_d.syncN = 1'b1;
                  h_d.gap = srb_pkg::GAP_CYC;
                  h_d.rspValid = 1'b1;
                  h_d.rspData = rxNext;
                  h_d.state = ST_GAP;
               end
               else
               begin
                  h_d.bitsLeft = h_q.bitsLeft - 5'h01;
                  h_d.tx = {h_q.tx[27:0], 1'b0};
                  h_d.sdi = h_q.tx[27];
               end
            end
         end
         ST_GAP:
         begin
            // Gives the device time to load readback before the next frame
            h_d.gap = h_q.gap - 5'h01;
            if (h_q.gap == 5'h00)
            begin
               h_d.ready = 1'b1;
               h_d.state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         h_q <= '{state: ST_IDLE, syncN: 1'b1, ready: 1'b1, default: '0};
      end
      else
      begin
         h_q <= h_d;
      end
   end

   assign link.sclk  = h_q.sclk;
   assign link.syncN = h_q.syncN;
   assign link.sdi   = h_q.sdi;
   assign cmdReady   = h_q.ready;
   assign rspValid   = h_q.rspValid;
   assign rspData    = h_q.rspData;
endmodule

// ===== rtl/srb_device.sv
`timescale 1ns/100ps
// Operation
// - Same read format on every serial port
// - Host first sends a readback command
// - Readback loads top 24 bits, five zeros
// - Data leaves on rising edges within frame
// - Host gives at least 24 rising edges
// - 24-bit flush must be a no-op
// - Flush word advised all ones
// - 29-bit command also shifts readback out
// - One channel bit; class picks register
// - DAC address uses write-side encoding
// - Control readback class bits read zero; code returns the command's class bits there
module srb_device (
   srb_if.dev                link,
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   output logic              rdReq,
   output logic              rdGlobal,
   output logic [1:0]        rdClass,
   output logic [1:0]        rdChan,
   output logic [5:0]        rdDacAddr,
   input  wire logic [23:0]  rdData
);
   typedef struct packed {
      logic [28:0]  shift;
      logic         sdo;
      logic         pend;
      logic         reqTgl;
      logic         glob;
      logic [1:0]   cls;
      logic [1:0]   chan;
      logic [5:0]   addr;
   } srb_link_s;

   typedef struct packed {
      logic [2:0]   tglSync;
      logic         rdReq;
      logic         glob;
      logic [1:0]   cls;
      logic [1:0]   chan;
      logic [5:0]   addr;
      logic [23:0]  rbWord;
   } srb_sys_s;

   srb_link_s l_q;
   srb_link_s l_d;
   srb_sys_s  s_q;
   srb_sys_s  s_d;
   logic [4:0]  edgeCnt_q;
   logic        frameRstN;
   logic [28:0] src;
   logic [28:0] cmd;

   function automatic logic srbDacAddrOk(input logic [5:0] a, input logic [1:0] cl);
      logic ok;
      begin
         unique case (a)
            srb_pkg::DAC_SHARED_OFFSET: ok = (cl == srb_pkg::CLS_INPUT);
            6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D: ok = 1'b1;
            6'h14, 6'h15, 6'h1C, 6'h1D: ok = 1'b1;
            6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25: ok = 1'b1;
            6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D: ok = 1'b1;
            default: ok = 1'b0;
         endcase
         return ok;
      end
   endfunction

   function automatic logic srbReadOk(input logic [28:0] c);
      logic [3:0]  ch;
      logic [1:0]  cl;
      logic [21:0] dat;
      logic        ok;
      begin
         ch  = c[srb_pkg::CHAN_MSB:srb_pkg::CHAN_LSB];
         cl  = c[srb_pkg::CLASS_MSB:srb_pkg::CLASS_LSB];
         dat = c[srb_pkg::DATA_MSB:0];
         ok  = 1'b0;
         if (!c[srb_pkg::BIT_RW])
         begin
            ok = 1'b0;
         end
         else if (ch == 4'h0)
         begin
            ok = (cl != srb_pkg::CLS_RSVD) && (dat == 22'h000000);
         end
         else if ($onehot(ch))
         begin
            if (cl == srb_pkg::CLS_CHAN)
            begin
               ok = (dat == 22'h000000);
            end
            else
            begin
               ok = (dat[21:6] == 16'h0000)
                  && srbDacAddrOk(dat[srb_pkg::ADDR_MSB:0], cl);
            end
         end
         return ok;
      end
   endfunction

   function automatic logic [1:0] srbChanIndex(input logic [3:0] ch);
      logic [1:0] idx;
      begin
         idx = 2'h0;
         for (int i = 0; i < 4; i++)
         begin
            if (ch[i])
            begin
               idx = 2'(i);
            end
         end
         return idx;
      end
   endfunction

   // Bit counter restarts while the frame is idle, since the link clock stops between frames
   assign frameRstN = rst_n & ~link.syncN;

   always_ff @(posedge link.sclk or negedge frameRstN)
   begin
      if (!frameRstN)
      begin
         edgeCnt_q <= srb_pkg::EDGE_FIRST;
      end
      else if (edgeCnt_q != srb_pkg::EDGE_SAT)
      begin
         edgeCnt_q <= edgeCnt_q + 5'h01;
      end
   end

   always_comb
   begin
      l_d = l_q;
      src = l_q.shift;
      // A pending readback enters the shift register on the frame's first edge
      if ((edgeCnt_q == srb_pkg::EDGE_FIRST) && l_q.pend)
      begin
         src = {s_q.rbWord, srb_pkg::FILL_ZERO};
      end
      cmd = {src[27:0], link.sdi};
      if (!link.syncN)
      begin
         l_d.shift = cmd;
         l_d.sdo = src[28];
         if (edgeCnt_q == srb_pkg::EDGE_FIRST)
         begin
            l_d.pend = 1'b0;
         end
         // Only a full-length command is decoded, so a short flush never reads
         if ((edgeCnt_q == srb_pkg::EDGE_LAST) && srbReadOk(cmd))
         begin
            l_d.pend = 1'b1;
            l_d.reqTgl = ~l_q.reqTgl;
            l_d.glob = (cmd[srb_pkg::CHAN_MSB:srb_pkg::CHAN_LSB] == 4'h0);
            l_d.cls = cmd[srb_pkg::CLASS_MSB:srb_pkg::CLASS_LSB];
            l_d.chan = srbChanIndex(cmd[srb_pkg::CHAN_MSB:srb_pkg::CHAN_LSB]);
            l_d.addr = cmd[srb_pkg::ADDR_MSB:0];
         end
      end
   end

   always_ff @(posedge link.sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         l_q <= '0;
      end
      else
      begin
         l_q <= l_d;
      end
   end

   // Request fields stay still from one toggle to the next, so they cross as a handshake
   always_comb
   begin
      s_d = s_q;
      s_d.tglSync = {s_q.tglSync[1:0], l_q.reqTgl};
      s_d.rdReq = 1'b0;
      if (s_q.tglSync[2] ^ s_q.tglSync[1])
      begin
         s_d.rdReq = 1'b1;
         s_d.glob = l_q.glob;
         s_d.cls = l_q.cls;
         s_d.chan = l_q.chan;
         s_d.addr = l_q.addr;
      end
      if (s_q.rdReq)
      begin
         if (s_q.glob)
         begin
            s_d.rbWord = {s_q.cls, rdData[21:0]};
         end
         else
         begin
            s_d.rbWord = rdData;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign link.sdo  = l_q.sdo;
   assign rdReq     = s_q.rdReq;
   assign rdGlobal  = s_q.glob;
   assign rdClass   = s_q.cls;
   assign rdChan    = s_q.chan;
   assign rdDacAddr = s_q.addr;
endmodule

// ===== tb/srb_chk.sv
`timescale 1ns/100ps
module srb_chk (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       sclk,
   input wire logic       syncN,
   input wire logic       sdi,
   input wire logic       sdo,
   input wire logic       rdReq,
   input wire logic       rdGlobal,
   input wire logic [1:0] rdClass,
   input wire logic [1:0] rdChan,
   input wire logic [5:0] rdDacAddr
);
   logic [5:0]  cnt;
   logic [28:0] sh;
   logic        sclkQ, syncQ, seen, ld;
   wire         fall = syncQ & ~syncN;
   wire         rise = sclk & ~sclkQ & ~syncN;

   // Decodable read commands, DAC addresses per the write-side table
   function automatic logic okRd(logic [28:0] c);
      logic [2:0] lo;
      lo = c[2:0];
      if (!c[28])
         return 1'b0;
      if (c[27:24] == 4'h0)
         return c[23:22] != 2'h2 && c[21:0] == 22'h0;
      if (!$onehot(c[27:24]))
         return 1'b0;
      if (c[23:22] == 2'h0)
         return c[21:0] == 22'h0;
      if (c[21:6] != 16'h0)
         return 1'b0;
      case (c[5:3])
         3'h0: return lo == 3'h0 && c[23:22] == 2'h3;
         3'h1, 3'h4, 3'h5: return lo <= 3'h5;
         3'h2, 3'h3: return lo == 3'h4 || lo == 3'h5;
         default: return 1'b0;
      endcase
   endfunction

   // Rise count and sampled command of the current frame
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         {cnt, sh, sclkQ, syncQ, seen, ld} <= {6'h00, 29'h00000000, 1'h0, 1'h1, 2'h0};
      else
      begin
         sclkQ <= sclk;
         syncQ <= syncN;
         cnt   <= fall ? 6'h00 : cnt + 6'(rise);
         sh    <= rise ? {sh[27:0], sdi} : sh;
         seen  <= ~fall & (seen | rdReq);
         ld    <= fall ? seen : ld;
      end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   req_issued_a: assert property ($rose(cnt == 6'h1D) && okRd(sh) |-> ##[0:8] rdReq)
      else $error("valid read gave no request");
   bad_read_silent_a: assert property ($rose(cnt == 6'h1D) && !okRd(sh)
      |-> (!rdReq) [*8])
      else $error("invalid read gave a request");
   req_full_frame_a: assert property (rdReq |-> cnt == 6'h1D)
      else $error("request without a full frame");
   req_pulse_a: assert property (rdReq |=> !rdReq)
      else $error("request longer than one cycle");
   global_fields_a: assert property (rdReq && sh[27:24] == 4'h0
      |-> rdGlobal && rdClass == sh[23:22])
      else $error("global request fields wrong");
   chan_fields_a: assert property (rdReq && sh[27:24] != 4'h0
      |-> !rdGlobal && rdClass == sh[23:22]
      && sh[27:24] == 4'h1 << rdChan && (rdClass == 2'h0 || rdDacAddr == sh[5:0]))
      else $error("channel request fields wrong");
   zero_tail_a: assert property (!syncN && ld && cnt >= 6'h19 |-> !sdo)
      else $error("readback tail not zero");
   sdo_framed_a: assert property ($changed(sdo) |-> $rose(sclk) && !syncN)
      else $error("data out moved outside a rising edge in frame");
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
   logic        sys_clk, rst_n, cmdValid, cmdShort, cmdReady, rspValid;
   logic        rdReq, rdGlobal, prevOk;
   logic [28:0] cmdWord;
   logic [23:0] rspData, rdData, prevExp;
   logic [24:0] note;
   logic [24:0] notes[$];
   logic [1:0]  rdClass, rdChan, cls;
   logic [5:0]  rdDacAddr, adr;
   logic [3:0]  ch;
   logic [2:0]  hiTab[3] = '{3'h1, 3'h4, 3'h5};
   int          fails, nTests, cycles, seed;

   srb_if srb_if_i ();
   srb_host srb_host_i (.link(srb_if_i), .sys_clk(sys_clk), .rst_n(rst_n), .cmdValid(cmdValid),
      .cmdShort(cmdShort), .cmdWord(cmdWord), .cmdReady(cmdReady), .rspValid(rspValid),
      .rspData(rspData));
   srb_device srb_device_i (.link(srb_if_i), .sys_clk(sys_clk), .rst_n(rst_n), .rdReq(rdReq),
      .rdGlobal(rdGlobal), .rdClass(rdClass), .rdChan(rdChan), .rdDacAddr(rdDacAddr),
      .rdData(rdData));
   srb_chk srb_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(srb_if_i.sclk),
      .syncN(srb_if_i.syncN), .sdi(srb_if_i.sdi), .sdo(srb_if_i.sdo), .rdReq(rdReq),
      .rdGlobal(rdGlobal), .rdClass(rdClass), .rdChan(rdChan), .rdDacAddr(rdDacAddr));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic endSim();
      $display("comparisons %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      nTests++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t readback %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [28:0] rd(logic [3:0] c, logic [1:0] k, logic [5:0] a);
      return {1'b1, c, k, 16'h0000, a};
   endfunction

   // Offers the command once the previous frame is done, so storage answers this read with salt
   task automatic send(input logic sh, input logic [28:0] w, input logic ok);
      logic [23:0] salt;
      salt = 24'($random(seed));
      notes.push_back({prevOk, prevExp});
      @(negedge sys_clk);
      while (cmdReady !== 1'b1)
         @(negedge sys_clk);
      cmdValid = 1'b1;
      cmdShort = sh;
      cmdWord = w;
      rdData = salt;
      @(negedge sys_clk);
      cmdValid = 1'b0;
      prevOk = ok;
      prevExp = w[27:24] == 4'h0 ? {w[23:22], salt[21:0]} : salt;
   endtask

   task automatic flush();
      send(1'b1, {5'h00, srb_pkg::FLUSH_CMD}, 1'b0);
   endtask

   always @(posedge sys_clk)
      if (rspValid === 1'b1 && notes.size() > 0)
      begin
         note = notes.pop_front();
         if (note[24])
            check(rspData, note[23:0]);
      end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         endSim();
      end
   end

   initial
   begin
      seed = 63765;
      rst_n = 1'b0;
      cmdValid = 1'b0;
      cmdShort = 1'b0;
      cmdWord = 29'h0;
      rdData = 24'h0;
      prevOk = 1'b0;
      prevExp = 24'h0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         send(1'b0, rd(4'h0, 2'(c), 6'h00), c != 2);
         flush();
      end
      for (int k = 0; k < 24; k++)
      begin
         ch = 4'h1 << ({$random(seed)} % 4);
         cls = 2'($random(seed));
         adr = {hiTab[{$random(seed)} % 3], 3'({$random(seed)} % 6)};
         if (cls == 2'h0 || (cls == 2'h3 && k[0]))
            adr = 6'h00;
         send(1'b0, rd(ch, cls, adr), 1'b1);
         if (k[1])
            flush();
      end
      send(1'b0, rd(4'h4, 2'h2, 6'h15), 1'b1);
      send(1'b0, rd(4'h3, 2'h1, 6'h08), 1'b0);
      send(1'b0, rd(4'h0, 2'h1, 6'h01), 1'b0);
      send(1'b0, rd(4'h1, 2'h2, 6'h00), 1'b0);
      send(1'b0, {1'b0, 4'h1, 2'h0, 22'h0}, 1'b0);
      send(1'b0, rd(4'h8, 2'h3, 6'h2D), 1'b1);
      flush();
      while (notes.size() != 0)
         @(posedge sys_clk);
      endSim();
   end
endmodule
